// file: logic/ufp_top.v
`timescale 1ns/1ps
`include "ufp_map.vh"
module ufp_top #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys,
  input  wire             nrst,
  input  wire [2:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [7:0]       reg_rdata,
  input  wire             rx_push,
  input  wire [7:0]       rx_char,
  input  wire [3:0]       rx_err,
  output reg  [7:0]       tx_data,
  output reg              tx_valid,
  input  wire             tx_take,
  input  wire             tx_shift_busy,
  output reg              irq
);

  function hit;
    input [2:0] a;
    input [2:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  localparam CW = AW + 1;
  localparam [CW-1:0] FULL_CNT = DEPTH;
  localparam [CW-1:0] ONE_CNT  = 1;

  reg  [11:0]   rx_mem [0:DEPTH-1];
  reg  [7:0]    tx_mem [0:DEPTH-1];
  reg  [AW-1:0] rx_wp_reg;
  reg  [AW-1:0] rx_rp_reg;
  reg  [CW-1:0] rx_cnt_reg;
  reg  [CW-1:0] err_cnt_reg;
  reg  [AW-1:0] tx_wp_reg;
  reg  [AW-1:0] tx_rp_reg;
  reg  [CW-1:0] tx_cnt_reg;
  reg  [3:0]    ier_reg;
  reg           fen_reg;
  reg           ovr_reg;
  reg  [3:0]    evt_sts_reg;
  reg  [3:0]    evt_en_reg;
  reg           idle_d_reg;

  wire wr_data = reg_wr & hit(reg_addr, `UFP_ADR_DATA);
  wire rd_data = reg_rd & hit(reg_addr, `UFP_ADR_DATA);
  wire wr_fcr  = reg_wr & hit(reg_addr, `UFP_ADR_IIR_FCR);
  wire rd_lsr  = reg_rd & hit(reg_addr, `UFP_ADR_LSR);

  // Leaving or entering FIFO mode flushes both sides so stale bytes never leak
  wire fen_chg = wr_fcr & (reg_wdata[`UFP_FCR_EN] != fen_reg);
  wire rx_clr  = wr_fcr & (reg_wdata[`UFP_FCR_RXCLR] | fen_chg);
  wire tx_clr  = wr_fcr & (reg_wdata[`UFP_FCR_TXCLR] | fen_chg);

  // Without FIFO mode each side holds a single character
  wire [CW-1:0] cap = fen_reg ? FULL_CNT : ONE_CNT;

  wire [11:0] rx_head = rx_mem[rx_rp_reg];
  wire        rx_any  = (rx_cnt_reg != {CW{1'b0}});
  wire        rx_full = (rx_cnt_reg >= cap);
  wire        rx_do_push = rx_push & ~rx_full & ~rx_clr;
  wire        rx_do_pop  = rd_data & rx_any & ~rx_clr;
  wire        push_bad   = rx_do_push & (|rx_err);
  wire        pop_bad    = rx_do_pop & (|rx_head[11:8]);

  wire        tx_any  = (tx_cnt_reg != {CW{1'b0}});
  wire        tx_full = (tx_cnt_reg >= cap);
  wire        tx_do_push = wr_data & ~tx_full & ~tx_clr;
  wire        tx_do_pop  = tx_take & tx_valid & ~tx_clr;

  // Line status assembled from live occupancy; no trigger or timeout bit exists
  wire        dr_bit   = rx_any;
  wire [3:0]  head_err = rx_any ? rx_head[11:8] : 4'h0;
  wire [3:0]  err_bits = head_err | {3'h0, ovr_reg};
  wire        thre_bit = ~tx_any;
  wire        temt_bit = ~tx_any & ~tx_shift_busy;
  wire        rfe_bit  = fen_reg & (err_cnt_reg != {CW{1'b0}});
  wire [7:0]  line_status_register = {rfe_bit, temt_bit, thre_bit, err_bits, dr_bit};

  // Each side reports through the identification only when its own enable is set
  reg  [3:0]  iid;
  always @*
  begin
    if (ier_reg[`UFP_IER_LS] & (|err_bits))
      iid = `UFP_IID_LS;
    else if (ier_reg[`UFP_IER_RX] & dr_bit)
      iid = `UFP_IID_RX;
    else if (ier_reg[`UFP_IER_TX] & thre_bit)
      iid = `UFP_IID_TX;
    else
      iid = `UFP_IID_NONE;
  end
  wire [7:0] interrupt_id_register = {(fen_reg ? `UFP_FIFO_MARK : 2'h0), 2'h0, iid};

  reg  [7:0] rdata_next;
  always @*
  begin
    case (reg_addr)
      `UFP_ADR_DATA:    rdata_next = rx_any ? rx_head[7:0] : 8'h00;
      `UFP_ADR_IER:     rdata_next = {4'h0, ier_reg};
      `UFP_ADR_IIR_FCR: rdata_next = interrupt_id_register;
      `UFP_ADR_EVT_STS: rdata_next = {4'h0, evt_sts_reg};
      `UFP_ADR_LSR:     rdata_next = line_status_register;
      `UFP_ADR_EVT_EN:  rdata_next = {4'h0, evt_en_reg};
      default:          rdata_next = 8'h00;
    endcase
  end

  wire [CW-1:0] tx_cnt_next = tx_clr ? {CW{1'b0}} :
                              tx_cnt_reg + {{AW{1'b0}}, tx_do_push} - {{AW{1'b0}}, tx_do_pop};
  wire          idle_now = temt_bit;
  wire [3:0]    ev;
  assign ev[`UFP_EV_RXCHAR]  = rx_do_push;
  assign ev[`UFP_EV_RXERR]   = push_bad;
  assign ev[`UFP_EV_TXEMPTY] = tx_any & (tx_cnt_next == {CW{1'b0}});
  assign ev[`UFP_EV_TXIDLE]  = idle_now & ~idle_d_reg;

  // Set wins over a same-cycle clear so no event is lost
  wire [3:0] clr_mask = (reg_wr & hit(reg_addr, `UFP_ADR_EVT_CLR)) ? reg_wdata[3:0] : 4'h0;
  wire [3:0] evt_sts_next = (evt_sts_reg & ~clr_mask) | ev;

  always @(posedge clk_sys)
  begin
    if (rx_do_push)
      rx_mem[rx_wp_reg] <= {rx_err, rx_char};
    if (tx_do_push)
      tx_mem[tx_wp_reg] <= reg_wdata;
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_wp_reg   <= {AW{1'b0}};
      rx_rp_reg   <= {AW{1'b0}};
      rx_cnt_reg  <= {CW{1'b0}};
      err_cnt_reg <= {CW{1'b0}};
      ovr_reg     <= 1'b0;
    end
    else if (rx_clr)
    begin
      rx_wp_reg   <= {AW{1'b0}};
      rx_rp_reg   <= {AW{1'b0}};
      rx_cnt_reg  <= {CW{1'b0}};
      err_cnt_reg <= {CW{1'b0}};
      ovr_reg     <= 1'b0;
    end
    else
    begin
      if (rx_do_push)
        rx_wp_reg <= (fen_reg ? rx_wp_reg + 1'b1 : {AW{1'b0}});
      if (rx_do_pop)
        rx_rp_reg <= (fen_reg ? rx_rp_reg + 1'b1 : {AW{1'b0}});
      rx_cnt_reg  <= rx_cnt_reg + {{AW{1'b0}}, rx_do_push} - {{AW{1'b0}}, rx_do_pop};
      err_cnt_reg <= err_cnt_reg + {{AW{1'b0}}, push_bad} - {{AW{1'b0}}, pop_bad};
      // Overrun keeps the stored bytes and flags the loss until status is read
      if (rx_push & rx_full)
        ovr_reg <= 1'b1;
      else if (rd_lsr)
        ovr_reg <= 1'b0;
    end
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_wp_reg  <= {AW{1'b0}};
      tx_rp_reg  <= {AW{1'b0}};
      tx_cnt_reg <= {CW{1'b0}};
      tx_data    <= 8'h00;
      tx_valid   <= 1'b0;
    end
    else
    begin
      if (tx_clr)
      begin
        tx_wp_reg <= {AW{1'b0}};
        tx_rp_reg <= {AW{1'b0}};
      end
      else
      begin
        if (tx_do_push)
          tx_wp_reg <= (fen_reg ? tx_wp_reg + 1'b1 : {AW{1'b0}});
        if (tx_do_pop)
          tx_rp_reg <= (fen_reg ? tx_rp_reg + 1'b1 : {AW{1'b0}});
      end
      tx_cnt_reg <= tx_cnt_next;
      // Valid drops for a cycle after each take so the head pointer settles first
      tx_valid   <= tx_any & ~tx_do_pop & ~tx_clr;
      tx_data    <= tx_mem[tx_rp_reg];
    end
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ier_reg     <= 4'h0;
      fen_reg     <= 1'b0;
      evt_sts_reg <= 4'h0;
      evt_en_reg  <= 4'h0;
      idle_d_reg  <= 1'b1;
      irq         <= 1'b0;
      reg_rdata   <= 8'h00;
    end
    else
    begin
      if (reg_wr & hit(reg_addr, `UFP_ADR_IER))
        ier_reg <= reg_wdata[3:0];
      if (wr_fcr)
        fen_reg <= reg_wdata[`UFP_FCR_EN];
      if (reg_wr & hit(reg_addr, `UFP_ADR_EVT_EN))
        evt_en_reg <= reg_wdata[3:0];
      evt_sts_reg <= evt_sts_next;
      idle_d_reg  <= idle_now;
      irq         <= |(evt_sts_next & evt_en_reg);
      reg_rdata   <= reg_rd ? rdata_next : 8'h00;
    end
  end

endmodule // ufp_top

// file: shared/ufp_map.vh
// Notes on behaviour
// - FIFO enable set with interrupt enables clear: status only through line status register; the event status register and irq still report events.
// - Receive and transmit sides enter polled operation independently.
// - Data-ready stays one while any byte remains in the receive FIFO.
// - Bits one to four report head character errors; INTERRUPT_ID_REGISTER untouched while line status enable zero.
// - Bit five is set when the transmit FIFO holds no characters.
// - Bit six is set only when transmit FIFO and shift register are empty.
// - Bit seven is set in FIFO mode while any stored receive character carries an error; it stays zero with FIFO enable clear.
// - Polled mode never indicates trigger level reached or character timeout.
// - Both FIFOs keep full buffering capacity in polled mode.
// - Data-ready sets when a character enters the FIFO, clears when FIFO empties.
// - Enable bit two enables line status identification; zero produces none.
// - Enable bit one enables transmit empty identification; zero leaves transmit polled.
`ifndef UFP_MAP_VH
`define UFP_MAP_VH
`define UFP_ADR_DATA    3'h0
`define UFP_ADR_IER     3'h1
`define UFP_ADR_IIR_FCR 3'h2
`define UFP_ADR_EVT_STS 3'h3
`define UFP_ADR_EVT_CLR 3'h4
`define UFP_ADR_LSR     3'h5
`define UFP_ADR_EVT_EN  3'h6
`define UFP_IER_RX      0
`define UFP_IER_TX      1
`define UFP_IER_LS      2
`define UFP_IER_MS      3
`define UFP_FCR_EN      0
`define UFP_FCR_RXCLR   1
`define UFP_FCR_TXCLR   2
`define UFP_IID_NONE    4'h1
`define UFP_IID_TX      4'h2
`define UFP_IID_RX      4'h4
`define UFP_IID_LS      4'h6
`define UFP_FIFO_MARK   2'h3
`define UFP_EV_RXCHAR   0
`define UFP_EV_RXERR    1
`define UFP_EV_TXEMPTY  2
`define UFP_EV_TXIDLE   3
`define UFP_ERR_W       4
`endif

// file: verification/ufp_top_properties.sv
`timescale 1ns/1ps
module ufp_top_properties (
  input logic       clk_sys,
  input logic       nrst,
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       rx_push,
  input logic [7:0] tx_data,
  input logic       tx_valid,
  input logic       tx_take,
  input logic       tx_shift_busy,
  input logic       irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_push; rx_push && !reg_wr; endsequence
  // A read or flush in between could empty the FIFO again
  sequence s_quiet; !reg_rd && !reg_wr; endsequence
  sequence s_lsr_rd; reg_rd && reg_addr == 3'h5; endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_ready_set: assert property (s_push ##1 s_quiet ##1 s_lsr_rd |=> reg_rdata[0])
    else $error("data ready missing");
  a_txe_busy: assert property (reg_rd && reg_addr == 3'h5 && tx_valid |=> !reg_rdata[5])
    else $error("tx empty while head valid");
  a_idle_both: assert property (s_lsr_rd |=> !reg_rdata[6] || reg_rdata[5] && !$past(tx_shift_busy))
    else $error("idle flag too early");
  a_no_timeout: assert property (reg_rd && reg_addr == 3'h2 |=> reg_rdata[3:0] != 4'hc)
    else $error("timeout id seen");
  a_take_drop: assert property (tx_valid && tx_take |=> !tx_valid)
    else $error("valid held after take");
  a_head_hold: assert property (tx_valid && !tx_take && !reg_wr |=> tx_valid && $stable(tx_data))
    else $error("head byte lost");
  a_irq_masked: assert property (reg_wr && reg_addr == 3'h6 && reg_wdata == 8'h00 ##1 !reg_wr |=> !irq)
    else $error("irq while masked");
endmodule // ufp_top_properties
bind ufp_top ufp_top_properties u_props (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_push(rx_push),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy), .irq(irq));

// file: verification/uart_fifo_polled_status_tb_top.sv
`timescale 1ns/1ps
module uart_fifo_polled_status_tb_top;
  logic       clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rx_push = 0, tx_take = 0, tx_shift_busy = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, rx_char = 8'h00;
  logic [3:0] rx_err = 4'h0;
  wire  [7:0] reg_rdata, tx_data;
  wire        tx_valid, irq;
  int         mismatches = 0, n_compared = 0, i;
  ufp_top dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_push(rx_push), .rx_char(rx_char), .rx_err(rx_err),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy), .irq(irq));
  initial
    forever #4 clk_sys = ~clk_sys;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  task take(input logic [7:0] e);
    int k;
    // Let the previous take settle before looking at valid again
    #1;
    for (k = 0; k < 8 && tx_valid !== 1'b1; k++)
      @(posedge clk_sys) #1;
    chk({7'h00, tx_valid}, 8'h01);
    if (tx_valid !== 1'b1)
      report_and_stop;
    chk(tx_data, e);
    @(posedge clk_sys);
    tx_take <= 1;
    @(posedge clk_sys);
    tx_take <= 0;
  endtask
  task irq_is(input logic [7:0] e);
    repeat (2) @(posedge clk_sys);
    #1 chk({7'h00, irq}, e);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #2 nrst = 1;
    wr(3'h2, 8'h01);
    wr(3'h1, 8'h00);
    rd(3'h2, 8'hc1);
    rd(3'h5, 8'h60);
    // One push more than the depth, back to back
    for (i = 0; i < 17; i++)
    begin
      @(posedge clk_sys);
      rx_push <= 1;
      rx_char <= 8'(8'h10 + i);
      rx_err <= (i == 1) ? 4'h2 : 4'h0;
    end
    @(posedge clk_sys);
    rx_push <= 0;
    rd(3'h5, 8'he3);
    rd(3'h5, 8'he1);
    rd(3'h0, 8'h10);
    rd(3'h5, 8'he5);
    for (i = 1; i < 16; i++)
      rd(3'h0, 8'(8'h10 + i));
    rd(3'h5, 8'h60);
    rd(3'h0, 8'h00);
    @(posedge clk_sys);
    tx_shift_busy <= 1;
    wr(3'h0, 8'ha5);
    wr(3'h0, 8'h5a);
    rd(3'h5, 8'h00);
    take(8'ha5);
    take(8'h5a);
    rd(3'h5, 8'h20);
    @(posedge clk_sys);
    tx_shift_busy <= 0;
    rd(3'h5, 8'h60);
    wr(3'h6, 8'h0f);
    irq_is(8'h01);
    rd(3'h3, 8'h0f);
    wr(3'h6, 8'h00);
    irq_is(8'h00);
    wr(3'h4, 8'h0f);
    rd(3'h3, 8'h00);
    wr(3'h1, 8'h02);
    rd(3'h2, 8'hc2);
    wr(3'h1, 8'h04);
    @(posedge clk_sys);
    rx_push <= 1;
    rx_err <= 4'h1;
    @(posedge clk_sys);
    rx_push <= 0;
    rd(3'h2, 8'hc6);
    report_and_stop;
  end
  initial
  begin
    #400000;
    mismatches++;
    report_and_stop;
  end
endmodule // uart_fifo_polled_status_tb_top
